// >>> core/icc_pkg.sv
// Contract
// (RQ1) Factory restore reloads every channel together
// (RQ2) 0-20mA calibration also serves 4-20mA range
// (RQ3) Protection lifts only on exact unlock key
// (RQ4) Zero command: one-hot mask picks channel
// (RQ5) New coefficients take effect immediately
// (RQ6) Span command: one-hot mask picks channel
// (RQ7) Writing zero to unlock register relocks
// (RQ8) Host calibrates zero before span
// (RQ9) Host waits about ten seconds settling; the testbench waits only 8 clock cycles
// (RQ10) Calibration applies to selected port range
// (RQ11) Run indicator on after power-up
// (RQ12) Wink mode blinks run indicator continuously
// (RQ13) Toggle key inverts wink mode
// (RQ14) Status register reports wink mode
// (RQ15) Fatal error keeps run indicator off
// (RQ16) Range selection applies to whole port
// (RQ17) Locked writes leave coefficients unchanged
// (RQ18) Non-one-hot masks are ignored
package icc_pkg;
  localparam int unsigned NCH       = 12;
  localparam int unsigned NPORT     = 3;
  localparam int unsigned NRANGE    = 4;
  localparam logic [7:0]  REG_UNLOCK   = 8'h15;
  localparam logic [7:0]  REG_SPAN     = 8'h16;
  localparam logic [7:0]  REG_ZERO     = 8'h17;
  localparam logic [7:0]  REG_WINK     = 8'h18;
  localparam logic [7:0]  REG_STATUS   = 8'h19;
  localparam logic [7:0]  REG_RESTORE  = 8'h1a;
  localparam logic [7:0]  REG_RANGE0   = 8'h1b;
  localparam logic [15:0] UNLOCK_KEY   = 16'h5e2a;
  localparam logic [15:0] LOCK_VAL     = 16'h0000;
  localparam logic [15:0] WINK_KEY     = 16'h5555;
  localparam logic [15:0] RESTORE_KEY  = 16'h0001;
  localparam int unsigned STAT_WINK    = 0;
  localparam int unsigned STAT_UNLOCK  = 1;
  localparam logic [1:0]  RANGE_RESET  = 2'h0;
  localparam logic [1:0]  RANGE_0_20   = 2'h0;
  localparam logic [1:0]  RANGE_4_20   = 2'h1;
  localparam real         CLK_MHZ      = 25.0;
  localparam real         BLINK_MS     = 250.0;
  localparam int unsigned BLINK_CYC    = int'(BLINK_MS * CLK_MHZ * 1000.0);
  localparam int unsigned BLINK_W      = 23;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } icc_req_t;

  typedef struct packed {
    logic [NCH-1:0] zero_cal;
    logic [NCH-1:0] span_cal;
    logic [1:0]     range;
  } icc_cal_t;

  typedef struct packed {
    logic                   unlocked;
    logic                   wink;
    logic [BLINK_W-1:0]     blink_cnt;
    logic                   blink;
    logic [NPORT-1:0][1:0]  range;
    logic [NCH-1:0]         zero_pulse;
    logic [NCH-1:0]         span_pulse;
    logic                   restore;
    logic [15:0]            rdata;
  } icc_state_t;
endpackage : icc_pkg

// >>> core/icc_top.sv
`timescale 1ns/1ps
`default_nettype none
module icc_top (
  input  wire logic                 mclk,          // 25 MHz clock
  input  wire logic                 nrst,          // Async reset, low
  input  wire icc_pkg::icc_req_t    req,           // Register access
  input  wire logic                 fatal_err,     // Fatal fault level
  output logic [15:0]               rdata,         // Read data
  output logic                      run_indicator, // Green run light
  output logic [icc_pkg::NCH-1:0]   zero_cal,      // Zero capture strobes
  output logic [icc_pkg::NCH-1:0]   span_cal,      // Span capture strobes
  output logic [icc_pkg::NPORT*2-1:0] cal_range,   // Range per port
  output logic                      restore_all    // Factory reload strobe
);
  import icc_pkg::*;

  icc_state_t st_ff;
  icc_state_t nxt_st;

  function automatic logic one_hot(input logic [15:0] m);
    logic [4:0] n;
    n = 5'h00;
    for (int i = 0; i < 16; i++)
      n = n + {4'h0, m[i]};
    return (n == 5'h01) && (m[15:NCH] == 4'h0);
  endfunction : one_hot

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.zero_pulse = '0;
    nxt_st.span_pulse = '0;
    nxt_st.restore = 1'b0;
    // Blink timebase only while winking
    if (st_ff.wink)
    begin
      if (st_ff.blink_cnt == BLINK_W'(BLINK_CYC - 1))
      begin
        nxt_st.blink_cnt = '0;
        nxt_st.blink = ~st_ff.blink; // RQ12
      end
      else
        nxt_st.blink_cnt = st_ff.blink_cnt + BLINK_W'(1);
    end
    else
    begin
      nxt_st.blink_cnt = '0;
      nxt_st.blink = 1'b0;
    end
    if (req.wr)
    begin
      unique case (req.addr)
        REG_UNLOCK:
        begin
          if (req.wdata == UNLOCK_KEY)
            nxt_st.unlocked = 1'b1; // RQ3
          else if (req.wdata == LOCK_VAL)
            nxt_st.unlocked = 1'b0; // RQ7
        end
        REG_ZERO:
          if (st_ff.unlocked && one_hot(req.wdata)) // RQ17 RQ18
            nxt_st.zero_pulse = req.wdata[NCH-1:0]; // RQ4 RQ5
        REG_SPAN:
          if (st_ff.unlocked && one_hot(req.wdata)) // RQ17 RQ18
            nxt_st.span_pulse = req.wdata[NCH-1:0]; // RQ6 RQ5
        REG_WINK:
          if (req.wdata == WINK_KEY)
            nxt_st.wink = ~st_ff.wink; // RQ13
        REG_RESTORE:
          if (st_ff.unlocked && req.wdata == RESTORE_KEY)
            nxt_st.restore = 1'b1; // RQ1
        default:
        begin
          for (int p = 0; p < NPORT; p++)
            if (req.addr == REG_RANGE0 + 8'(p))
              nxt_st.range[p] = req.wdata[1:0]; // RQ16
        end
      endcase
    end
    nxt_st.rdata = 16'h0000;
    if (req.rd)
    begin
      if (req.addr == REG_UNLOCK)
        nxt_st.rdata = st_ff.unlocked ? UNLOCK_KEY : LOCK_VAL;
      else if (req.addr == REG_STATUS)
      begin
        nxt_st.rdata[STAT_WINK] = st_ff.wink; // RQ14
        nxt_st.rdata[STAT_UNLOCK] = st_ff.unlocked;
      end
      else
        for (int p = 0; p < NPORT; p++)
          if (req.addr == REG_RANGE0 + 8'(p))
            nxt_st.rdata = {14'h0000, st_ff.range[p]};
    end
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_ff <= '0;
      for (int p = 0; p < NPORT; p++)
        st_ff.range[p] <= RANGE_RESET;
    end
    else
      st_ff <= nxt_st;
  end

  // 4-20mA shares 0-20mA coefficients
  always_comb
  begin
    for (int p = 0; p < NPORT; p++)
      cal_range[2*p +: 2] = (st_ff.range[p] == RANGE_4_20) ? RANGE_0_20
                                                            : st_ff.range[p]; // RQ2 RQ10
  end

  assign zero_cal      = st_ff.zero_pulse;
  assign span_cal      = st_ff.span_pulse;
  assign restore_all   = st_ff.restore;
  assign rdata         = st_ff.rdata;
  assign run_indicator = !fatal_err && (st_ff.wink ? st_ff.blink : 1'b1); // RQ11 RQ15 RQ12
endmodule : icc_top
`default_nettype wire

// >>> dv/icc_properties.sv
`timescale 1ns/1ps
`default_nettype none
module icc_properties (
  input wire logic              mclk,          // Clock
  input wire logic              nrst,          // Reset
  input wire icc_pkg::icc_req_t req,           // Access
  input wire logic              fatal_err,     // Fault
  input wire logic [15:0]       rdata,         // Read
  input wire logic              run_indicator, // Light
  input wire logic [11:0]       zero_cal,      // Zero
  input wire logic [11:0]       span_cal,      // Span
  input wire logic              restore_all    // Reload
);
  import icc_pkg::*;
  logic ul_ff, wk_ff;
  wire logic [15:0] d = req.wdata;
  wire logic oh = $onehot(d) && !d[15:12];
  wire logic wz = req.wr && req.addr == REG_ZERO;
  wire logic ws = req.wr && req.addr == REG_SPAN;
  logic [BLINK_W:0] still_ff;
  logic             run_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst) {ul_ff, wk_ff} <= 2'h0;
    else if (req.wr && req.addr == REG_UNLOCK && d inside {UNLOCK_KEY, LOCK_VAL})
      ul_ff <= d == UNLOCK_KEY;
    else if (req.wr && req.addr == REG_WINK && d == WINK_KEY)
      wk_ff <= !wk_ff;
  // Cycles the light has held one level while winking
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst)
    begin
      still_ff <= '0;
      run_q    <= 1'b0;
    end
    else
    begin
      run_q    <= run_indicator;
      still_ff <= (wk_ff && !fatal_err && run_indicator == run_q) ? still_ff + 1'b1 : '0;
    end
  property p_zero; wz && ul_ff && oh |=> zero_cal == $past(d[11:0]); endproperty
  a_zero: assert property (p_zero) else $error("zero");
  property p_span; ws && ul_ff && oh |=> span_cal == $past(d[11:0]); endproperty
  a_span: assert property (p_span) else $error("span");
  property p_lock; (wz || ws) && !ul_ff |=> !zero_cal && !span_cal; endproperty
  a_lock: assert property (p_lock) else $error("lock");
  property p_mask; (wz || ws) && !oh |=> !zero_cal && !span_cal; endproperty
  a_mask: assert property (p_mask) else $error("mask");
  property p_rest;
    req.wr && req.addr == REG_RESTORE && ul_ff && d == RESTORE_KEY |=> restore_all;
  endproperty
  a_rest: assert property (p_rest) else $error("restore");
  property p_fat; fatal_err |-> !run_indicator; endproperty
  a_fat: assert property (p_fat) else $error("fatal");
  property p_run; !fatal_err && !wk_ff && !$past(wk_ff) |-> run_indicator; endproperty
  a_run: assert property (p_run) else $error("run");
  property p_stat;
    req.rd && req.addr == REG_STATUS |=> rdata[1:0] == {$past(ul_ff), $past(wk_ff)};
  endproperty
  a_stat: assert property (p_stat) else $error("status");
  property p_blink; wk_ff && !fatal_err |-> still_ff <= (BLINK_W+1)'(BLINK_CYC); endproperty
  a_blink: assert property (p_blink) else $error("blink");
endmodule : icc_properties
bind icc_top icc_properties i_chk (.mclk(mclk), .nrst(nrst), .req(req), .fatal_err(fatal_err),
  .rdata(rdata), .run_indicator(run_indicator), .zero_cal(zero_cal), .span_cal(span_cal),
  .restore_all(restore_all));
`default_nettype wire

// >>> dv/icc_host.sv
`timescale 1ns/1ps
`default_nettype none
module icc_host (
  input  wire logic            mclk, // Clock
  output var icc_pkg::icc_req_t req  // Access
);
  import icc_pkg::*;
  initial req = '0;
  task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] wd);
    @(posedge mclk);
    req <= '{w, !w, a, wd};
    @(posedge mclk);
    req <= '0;
  endtask : acc
endmodule : icc_host
`default_nettype wire

// >>> dv/tb_input_calibration_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_input_calibration_control;
  import icc_pkg::*;
  logic mclk = 0, nrst = 0, fatal_err = 0, rd_q = 0, run_indicator, restore_all;
  icc_req_t req;
  logic [15:0] rdata;
  logic [11:0] zero_cal, span_cal, m;
  logic [5:0]  cal_range;
  logic [40:0] q[$];
  int failures = 0, comparisons = 0;
  icc_host i_host (.mclk(mclk), .req(req));
  icc_top i_dut (.mclk(mclk), .nrst(nrst), .req(req), .fatal_err(fatal_err), .rdata(rdata),
    .run_indicator(run_indicator), .zero_cal(zero_cal), .span_cal(span_cal),
    .cal_range(cal_range),
    .restore_all(restore_all));
  initial forever #20 mclk = !mclk;
  task automatic test_done;
    if (failures == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done
  task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] wd, logic [40:0] e);
    if (!w || e) q.push_back(e);
    i_host.acc(w, a, wd);
  endtask : acc
  always @(posedge mclk) rd_q <= req.rd;
  always @(negedge mclk)
    if (nrst && (rd_q || {restore_all, span_cal, zero_cal} !== 25'h0))
    begin
      comparisons++;
      if (q.size() == 0 || q[0] !== {restore_all, span_cal, zero_cal, rdata})
      begin
        $display("wrong value %0t result %h", $time, {restore_all, span_cal, zero_cal, rdata});
        failures++;
      end
      if (q.size()) void'(q.pop_front());
    end
  initial
  begin
    void'($urandom(32'h2871));
    repeat (6) @(posedge mclk);
    nrst <= 1;
    acc(1'b1, REG_ZERO, 16'h0001, 41'h0);
    acc(1'b1, REG_UNLOCK, 16'h5e2b, 41'h0);
    acc(1'b1, REG_ZERO, 16'h0001, 41'h0);
    acc(1'b1, REG_RANGE0, {14'h0, RANGE_4_20}, 41'h0);
    acc(1'b1, REG_RANGE0 + 8'h01, 16'h0002, 41'h0);
    acc(1'b0, REG_RANGE0 + 8'h01, 16'h0000, 41'h2);
    @(negedge mclk);
    comparisons++;
    if (cal_range !== {2'h0, 2'h2, RANGE_0_20})
    begin
      $display("wrong value %0t range %h", $time, cal_range);
      failures++;
    end
    acc(1'b1, REG_UNLOCK, UNLOCK_KEY, 41'h0);
    acc(1'b0, REG_STATUS, 16'h0000, 41'h2);
    repeat (4)
    begin
      m = 12'h1 << ($urandom % 12);
      repeat (8) @(posedge mclk);
      acc(1'b1, REG_ZERO, {4'h0, m}, {13'h0, m, 16'h0});
      repeat (8) @(posedge mclk);
      acc(1'b1, REG_SPAN, {4'h0, m}, {1'b0, m, 28'h0});
    end
    acc(1'b1, REG_ZERO, 16'h0003, 41'h0);
    acc(1'b1, REG_SPAN, 16'h1000, 41'h0);
    acc(1'b1, REG_RESTORE, RESTORE_KEY, 41'h1 << 40);
    acc(1'b1, REG_WINK, WINK_KEY, 41'h0);
    acc(1'b0, REG_STATUS, 16'h0000, 41'h3);
    acc(1'b1, REG_WINK, WINK_KEY, 41'h0);
    acc(1'b1, REG_UNLOCK, LOCK_VAL, 41'h0);
    acc(1'b1, REG_ZERO, 16'h0020, 41'h0);
    acc(1'b1, REG_RESTORE, RESTORE_KEY, 41'h0);
    fatal_err <= 1;
    repeat (3) @(posedge mclk);
    fatal_err <= 0;
    repeat (4) @(posedge mclk);
    if (q.size()) failures++;
    test_done();
  end
endmodule : tb_input_calibration_control
`default_nettype wire
